// *** tb/data_mem_test.sv ***
// Purpose: Self-checking bench for the data memory, banks, bit area and stack pointer.
// Assumes: One command at a time; each answer is read one cycle after it is taken.
// Notes:   Expected values come only from the memory map, never from the design.
`timescale 1ns/1ps
module data_mem_test;
    import data_mem_pkg::*;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       cmd_valid = 1'b0;
    op_t        cmd_op = OP_READ;
    mode_t      cmd_mode = MODE_DIRECT;
    logic [7:0] cmd_addr = 8'h00;
    logic       cmd_ptr_sel = 1'b0;
    logic [7:0] cmd_wdata = 8'h00;
    logic       cmd_wbit = 1'b0;
    logic [7:0] program_status_word = 8'h00;
    logic [7:0] func_reg_rdata, rsp_data, func_reg_addr, func_reg_wdata, stack_top_pointer;
    logic       rsp_valid, rsp_bit, func_reg_sel, func_reg_we, func_reg_bit_op, func_reg_wbit;
    logic [2:0] func_reg_bit_idx;
    int         mismatches = 0;
    int         cmp_count = 0;
    int         cycles = 0;

    data_mem dut (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_mode(cmd_mode), .cmd_addr(cmd_addr), .cmd_ptr_sel(cmd_ptr_sel),
        .cmd_wdata(cmd_wdata), .cmd_wbit(cmd_wbit), .program_status_word(program_status_word),
        .func_reg_rdata(func_reg_rdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_bit(rsp_bit), .func_reg_sel(func_reg_sel), .func_reg_we(func_reg_we),
        .func_reg_bit_op(func_reg_bit_op), .func_reg_bit_idx(func_reg_bit_idx),
        .func_reg_addr(func_reg_addr), .func_reg_wdata(func_reg_wdata),
        .func_reg_wbit(func_reg_wbit), .stack_top_pointer(stack_top_pointer));
    func_reg_space_model far_side (.clk(clk), .func_reg_sel(func_reg_sel),
        .func_reg_we(func_reg_we), .func_reg_bit_op(func_reg_bit_op),
        .func_reg_bit_idx(func_reg_bit_idx), .func_reg_addr(func_reg_addr),
        .func_reg_wdata(func_reg_wdata), .func_reg_wbit(func_reg_wbit),
        .func_reg_rdata(func_reg_rdata));

    // Free-running clock of 50 ns.
    always #25 clk = ~clk;

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // A hang is cut short well beyond the hundred or so cycles the sequence needs.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            mismatches++;
            test_done;
        end
    end

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    // One command is held for exactly one edge, then the answer is sampled once it settles.
    task automatic cmd(input op_t op, input mode_t md, input logic [7:0] a, input logic p,
                       input logic [7:0] wd, input logic wb);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_mode <= md;
        cmd_addr <= a;
        cmd_ptr_sel <= p;
        cmd_wdata <= wd;
        cmd_wbit <= wb;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1 chk1("rsp_valid", 1'b1, rsp_valid);
    endtask

    task automatic bank(input int b);
        @(posedge clk);
        program_status_word <= 8'(b << 3);
    endtask

    // Main sequence: stack, banks and upper RAM, special space, bit area, second reset.
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1 chk8("stack_top_pointer", 8'h07, stack_top_pointer);
        cmd(OP_PUSH, MODE_DIRECT, 8'h00, 1'b0, 8'hAA, 1'b0);
        chk8("stack_top_pointer", 8'h08, stack_top_pointer);
        cmd(OP_READ, MODE_DIRECT, 8'h08, 1'b0, 8'h00, 1'b0);
        chk8("first_push", 8'hAA, rsp_data);
        cmd(OP_POP, MODE_BIT, 8'h00, 1'b0, 8'h00, 1'b0);
        chk8("pop_data", 8'hAA, rsp_data);
        chk8("stack_top_pointer", 8'h07, stack_top_pointer);
        cmd(OP_WRITE, MODE_DIRECT, 8'h81, 1'b0, 8'hFE, 1'b0);
        chk8("stack_top_pointer", 8'hFE, stack_top_pointer);
        cmd(OP_READ, MODE_DIRECT, 8'h81, 1'b0, 8'h00, 1'b0);
        chk8("pointer_read", 8'hFE, rsp_data);
        cmd(OP_PUSH, MODE_DIRECT, 8'h00, 1'b0, 8'h11, 1'b0);
        cmd(OP_PUSH, MODE_DIRECT, 8'h00, 1'b0, 8'h22, 1'b0);
        chk8("stack_top_pointer", 8'h00, stack_top_pointer);
        cmd(OP_READ, MODE_DIRECT, 8'h00, 1'b0, 8'h00, 1'b0);
        chk8("wrap_push", 8'h22, rsp_data);
        cmd(OP_POP, MODE_DIRECT, 8'h00, 1'b0, 8'h00, 1'b0);
        cmd(OP_POP, MODE_DIRECT, 8'h00, 1'b0, 8'h00, 1'b0);
        chk8("pop_top", 8'h11, rsp_data);
        for (int b = 0; b < 4; b++) begin
            bank(b);
            cmd(OP_WRITE, MODE_DIRECT, 8'(8 * b), 1'b0, 8'(8'h80 + b), 1'b0);
            cmd(OP_WRITE, MODE_INDIRECT, 8'h00, 1'b0, 8'(8'hC0 + b), 1'b0);
        end
        cmd(OP_WRITE, MODE_DIRECT, 8'h80, 1'b0, 8'h33, 1'b0);
        for (int b = 0; b < 4; b++) begin
            bank(b);
            cmd(OP_READ, MODE_INDIRECT, 8'h00, 1'b0, 8'h00, 1'b0);
            chk8("upper_ram", 8'(8'hC0 + b), rsp_data);
            cmd(OP_READ, MODE_DIRECT, 8'(8 * b), 1'b0, 8'h00, 1'b0);
            chk8("bank_reg", 8'(8'h80 + b), rsp_data);
        end
        cmd(OP_WRITE, MODE_DIRECT, 8'h19, 1'b0, 8'h45, 1'b0);
        cmd(OP_WRITE, MODE_INDIRECT, 8'h00, 1'b1, 8'h77, 1'b0);
        cmd(OP_READ, MODE_DIRECT, 8'h45, 1'b0, 8'h00, 1'b0);
        chk8("lower_ram", 8'h77, rsp_data);
        cmd(OP_WRITE, MODE_DIRECT, 8'h18, 1'b0, 8'h81, 1'b0);
        cmd(OP_WRITE, MODE_INDIRECT, 8'h00, 1'b0, 8'hC5, 1'b0);
        chk8("stack_top_pointer", 8'hFE, stack_top_pointer);
        cmd(OP_READ, MODE_INDIRECT, 8'h00, 1'b0, 8'h00, 1'b0);
        chk8("upper_ram", 8'hC5, rsp_data);
        cmd(OP_WRITE, MODE_BIT, 8'h82, 1'b0, 8'h00, 1'b1);
        cmd(OP_READ, MODE_DIRECT, 8'h80, 1'b0, 8'h00, 1'b0);
        chk8("special_reg", 8'h37, rsp_data);
        cmd(OP_READ, MODE_BIT, 8'h82, 1'b0, 8'h00, 1'b0);
        chk1("reg_bit_read", 1'b1, rsp_bit);
        cmd(OP_WRITE, MODE_DIRECT, 8'h22, 1'b0, 8'h00, 1'b0);
        cmd(OP_WRITE, MODE_DIRECT, 8'h2F, 1'b0, 8'h00, 1'b0);
        cmd(OP_WRITE, MODE_DIRECT, 8'h20, 1'b0, 8'hFF, 1'b0);
        cmd(OP_WRITE, MODE_BIT, 8'h13, 1'b0, 8'h00, 1'b1);
        cmd(OP_WRITE, MODE_BIT, 8'h7F, 1'b0, 8'h00, 1'b1);
        cmd(OP_WRITE, MODE_BIT, 8'h00, 1'b0, 8'hFF, 1'b0);
        cmd(OP_READ, MODE_DIRECT, 8'h22, 1'b0, 8'h00, 1'b0);
        chk8("bit_byte", 8'h08, rsp_data);
        cmd(OP_READ, MODE_DIRECT, 8'h2F, 1'b0, 8'h00, 1'b0);
        chk8("bit_byte", 8'h80, rsp_data);
        cmd(OP_READ, MODE_DIRECT, 8'h20, 1'b0, 8'h00, 1'b0);
        chk8("bit_byte", 8'hFE, rsp_data);
        cmd(OP_READ, MODE_BIT, 8'h13, 1'b0, 8'h00, 1'b0);
        chk1("bit_read", 1'b1, rsp_bit);
        cmd(OP_READ, MODE_BIT, 8'h12, 1'b0, 8'h00, 1'b0);
        chk1("bit_read", 1'b0, rsp_bit);
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        #1 chk8("stack_top_pointer", 8'h07, stack_top_pointer);
        test_done;
    end
endmodule // data_mem_test

// *** tb/sfr_space_model.sv ***
// Purpose: Behavioural function register space on the forwarded func_reg_* port group.
// Assumes: Read data is returned in the same cycle as func_reg_sel.
// Notes:   Unselected cycles show a changing pattern, so stale data never looks valid.
`timescale 1ns/1ps
module func_reg_space_model (
    input  wire logic       clk,
    input  wire logic       func_reg_sel,
    input  wire logic       func_reg_we,
    input  wire logic       func_reg_bit_op,
    input  wire logic [2:0] func_reg_bit_idx,
    input  wire logic [7:0] func_reg_addr,
    input  wire logic [7:0] func_reg_wdata,
    input  wire logic       func_reg_wbit,
    output logic      [7:0] func_reg_rdata
);
    logic [7:0] regs [128];
    logic [7:0] noise_q = 8'h5A;
    // Writes land at the edge; a bit write merges into the held byte here.
    always @(posedge clk) begin
        noise_q <= ~noise_q + 8'h01;
        if (func_reg_sel && func_reg_we && func_reg_bit_op) begin
            regs[func_reg_addr[6:0]][func_reg_bit_idx] <= func_reg_wbit;
        end else if (func_reg_sel && func_reg_we) begin
            regs[func_reg_addr[6:0]] <= func_reg_wdata;
        end
    end
    // Reserved places give back whatever was stored; nothing more is promised there.
    assign func_reg_rdata = func_reg_sel ? regs[func_reg_addr[6:0]] : noise_q;
endmodule // func_reg_space_model

// *** verilog/data_mem.sv ***
// Purpose: Internal data memory with register banks, bit area, upper RAM and stack pointer.
// Assumes: The core issues at most one command a cycle; bank bits arrive on the same clock.
// Notes:   Every command answers one cycle later; direct upper addresses other than 0x81 leave the block.
`timescale 1ns/1ps
module data_mem
    import data_mem_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       cmd_valid,
    input  wire op_t        cmd_op,
    input  wire mode_t      cmd_mode,
    input  wire logic [7:0] cmd_addr,
    input  wire logic       cmd_ptr_sel,
    input  wire logic [7:0] cmd_wdata,
    input  wire logic       cmd_wbit,
    input  wire logic [7:0] program_status_word,
    input  wire logic [7:0] func_reg_rdata,
    output logic            rsp_valid,
    output logic      [7:0] rsp_data,
    output logic            rsp_bit,
    output logic            func_reg_sel,
    output logic            func_reg_we,
    output logic            func_reg_bit_op,
    output logic      [2:0] func_reg_bit_idx,
    output logic      [7:0] func_reg_addr,
    output logic      [7:0] func_reg_wdata,
    output logic            func_reg_wbit,
    output logic      [7:0] stack_top_pointer
);

    // Byte that holds a given bit address: bit area below 0x80, register byte above.
    function automatic logic [7:0] bit_home_byte(input logic [7:0] bit_addr);
        if (bit_addr[7]) begin
            bit_home_byte = {bit_addr[7:3], 3'b000};
        end else begin
            bit_home_byte = {BIT_AREA_HIGH, bit_addr[6:3]};
        end
    endfunction

    logic       bank_select_low;
    logic       bank_select_high;
    logic [1:0] active_bank;
    logic [7:0] ptr_loc;
    logic [7:0] ind_addr;
    logic [7:0] ram_addr;
    logic [7:0] ram_rdata;
    logic       ram_we;
    logic [7:0] ram_wdata;
    logic [7:0] ram_mask;
    logic       is_bit;
    logic       is_stk_ptr;
    logic       to_func_reg;
    logic       is_stack;
    logic [7:0] ptr_rdata;
    logic [7:0] stk_ptr_q;
    logic [7:0] stk_ptr_d;
    logic       rsp_valid_q;
    logic       rsp_valid_d;
    logic [7:0] rsp_data_q;
    logic [7:0] rsp_data_d;
    logic       rsp_bit_q;
    logic       rsp_bit_d;

    // The two bank select bits pick which eight bytes serve as working registers.
    assign bank_select_low  = program_status_word[BANK_SEL_LOW_POS];  // RULE7
    assign bank_select_high = program_status_word[BANK_SEL_HIGH_POS]; // RULE7
    assign active_bank      = {bank_select_high, bank_select_low};    // RULE7
    // Pointer register location is bank times eight plus register zero or one.
    assign ptr_loc  = {3'b000, active_bank, 2'b00, cmd_ptr_sel}; // RULE3 RULE8
    assign ind_addr = ptr_rdata;                                 // RULE8

    // Command decode. Bit handling follows the mode field outside push and pop, never the address.
    always_comb begin
        is_stack = (cmd_op == OP_PUSH) || (cmd_op == OP_POP);
        is_bit   = !is_stack && (cmd_mode == MODE_BIT);                          // RULE10
        is_stk_ptr  = !is_stack && (cmd_mode == MODE_DIRECT) && (cmd_addr == STACK_PTR_ADDR);
        to_func_reg = cmd_valid && !is_stack && !is_stk_ptr && cmd_addr[7]
                   && ((cmd_mode == MODE_DIRECT) || (cmd_mode == MODE_BIT));     // RULE6 RULE14
        if (cmd_op == OP_PUSH) begin
            ram_addr = stk_ptr_q + 8'h01;                                        // RULE11 RULE13
        end else if (cmd_op == OP_POP) begin
            ram_addr = stk_ptr_q;                                                // RULE16
        end else if (cmd_mode == MODE_INDIRECT) begin
            ram_addr = ind_addr;                                                 // RULE2 RULE5 RULE6
        end else if (is_bit) begin
            ram_addr = bit_home_byte(cmd_addr);                                  // RULE4 RULE9
        end else begin
            ram_addr = cmd_addr;                                                 // RULE2
        end
        ram_we    = cmd_valid && !to_func_reg && !is_stk_ptr
                    && ((cmd_op == OP_WRITE) || (cmd_op == OP_PUSH));            // RULE1
        ram_mask  = is_bit ? (8'h01 << cmd_addr[2:0]) : FULL_BYTE_MASK;          // RULE9
        ram_wdata = is_bit ? {8{cmd_wbit}} : cmd_wdata;
    end

    // Register space traffic is passed straight through so the owning block sees it this cycle.
    always_comb begin
        func_reg_sel     = to_func_reg;                                          // RULE14
        func_reg_we      = to_func_reg && (cmd_op == OP_WRITE);
        func_reg_bit_op  = to_func_reg && is_bit;                                // RULE10
        func_reg_bit_idx = cmd_addr[2:0];
        func_reg_addr    = is_bit ? bit_home_byte(cmd_addr) : cmd_addr;
        func_reg_wdata   = cmd_wdata;
        func_reg_wbit    = cmd_wbit;
    end

    ram_store u_ram (
        .clk       (clk),
        .wr_en     (ram_we),
        .wr_addr   (ram_addr),
        .wr_data   (ram_wdata),
        .wr_mask   (ram_mask),
        .rd_addr_a (ram_addr),
        .rd_data_a (ram_rdata),
        .rd_addr_b (ptr_loc),
        .rd_data_b (ptr_rdata)
    );

    // Stack pointer next value; a direct write at its address reloads it.
    always_comb begin
        stk_ptr_d = stk_ptr_q;
        if (cmd_valid) begin
            case (cmd_op)
                OP_PUSH: begin
                    stk_ptr_d = stk_ptr_q + 8'h01;                               // RULE11
                end
                OP_POP: begin
                    stk_ptr_d = stk_ptr_q - 8'h01;                               // RULE16
                end
                OP_WRITE: begin
                    if (is_stk_ptr) begin
                        stk_ptr_d = cmd_wdata;                                   // RULE11
                    end
                end
                default: begin
                    stk_ptr_d = stk_ptr_q;
                end
            endcase
        end
    end

    // Answer data is captured so the core reads a stable value for a whole cycle.
    always_comb begin
        rsp_valid_d = cmd_valid;
        rsp_data_d  = rsp_data_q;
        rsp_bit_d   = rsp_bit_q;
        if (cmd_valid && ((cmd_op == OP_READ) || (cmd_op == OP_POP))) begin
            if (to_func_reg) begin
                rsp_data_d = func_reg_rdata;                                     // RULE14
            end else if (is_stk_ptr) begin
                rsp_data_d = stk_ptr_q;                                          // RULE11
            end else begin
                rsp_data_d = ram_rdata;                                          // RULE16
            end
            rsp_bit_d = to_func_reg ? func_reg_rdata[cmd_addr[2:0]] : ram_rdata[cmd_addr[2:0]];
        end
    end

    // Reset loads the pointer so that the first push lands in bank one.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stk_ptr_q   <= STACK_PTR_RESET;                                      // RULE12
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= 8'h00;
            rsp_bit_q   <= 1'b0;
        end else begin
            stk_ptr_q   <= stk_ptr_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q  <= rsp_data_d;
            rsp_bit_q   <= rsp_bit_d;
        end
    end

    // Every answer and the pointer leave straight from their flip-flops.
    assign rsp_valid         = rsp_valid_q;
    assign rsp_data          = rsp_data_q;
    assign rsp_bit           = rsp_bit_q;
    assign stack_top_pointer = stk_ptr_q;

    // Helper flag marks the first edge after reset release for the reset check.
    logic seen_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= 1'b1;
        end
    end

    // Stack requests as the checks below see them.
    sequence seq_push_req;
        cmd_valid && (cmd_op == OP_PUSH);
    endsequence

    sequence seq_pop_req;
        cmd_valid && (cmd_op == OP_POP);
    endsequence

    chk_stack_reset_value: assert property (@(posedge clk) disable iff (!rstn) // RULE12
        !seen_q |-> (stk_ptr_q == STACK_PTR_RESET))
        else $error("Stack pointer did not come out of reset at its reset value.");

    chk_push_order: assert property (@(posedge clk) disable iff (!rstn) // RULE11
        seq_push_req |=> (stk_ptr_q == $past(stk_ptr_q) + 8'h01)
                         && (u_ram.mem_q[stk_ptr_q] == $past(cmd_wdata)))
        else $error("Push did not store at pointer plus one and then increment.");

    chk_pop_order: assert property (@(posedge clk) disable iff (!rstn) // RULE16
        seq_pop_req |=> (stk_ptr_q == $past(stk_ptr_q) - 8'h01) && rsp_valid
                        && (rsp_data == u_ram.mem_q[$past(stk_ptr_q)]))
        else $error("Pop did not return the byte at the pointer and then decrement.");

    chk_direct_upper: assert property (@(posedge clk) disable iff (!rstn) // RULE14
        (cmd_valid && cmd_mode == MODE_DIRECT && !is_stack && cmd_addr[7]
         && cmd_addr != STACK_PTR_ADDR) |-> (func_reg_sel && !ram_we))
        else $error("Direct upper access did not go to register space.");

    chk_indirect_ram: assert property (@(posedge clk) disable iff (!rstn) // RULE5
        (cmd_valid && cmd_mode == MODE_INDIRECT && !is_stack)
        |-> (!func_reg_sel && ram_addr == u_ram.mem_q[ptr_loc]))
        else $error("Indirect access did not use the pointer register into RAM.");

    chk_bank_pointer: assert property (@(posedge clk) disable iff (!rstn) // RULE8
        cmd_valid |-> (ptr_loc == ({6'b000000, program_status_word[4:3]} << 3)
                                  + {7'b0000000, cmd_ptr_sel}))
        else $error("Pointer register location does not follow the active bank.");

    chk_bit_write_map: assert property (@(posedge clk) disable iff (!rstn) // RULE9
        (cmd_valid && cmd_mode == MODE_BIT && cmd_op == OP_WRITE && !cmd_addr[7])
        |=> (u_ram.mem_q[8'h20 + {4'h0, $past(cmd_addr[6:3])}][$past(cmd_addr[2:0])]
             == $past(cmd_wbit)))
        else $error("Bit write did not land on the mapped bit of the bit area.");

    chk_answer_timing: assert property (@(posedge clk) disable iff (!rstn) // RULE1
        cmd_valid |=> rsp_valid ##1 (rsp_valid == $past(cmd_valid)))
        else $error("Answer did not follow its command by exactly one cycle.");

endmodule // data_mem

// *** verilog/data_mem_pkg.sv ***
// Purpose: Shared constants and types for the internal data memory and stack pointer block.
// Assumes: One 20 MHz clock, asynchronous active-low reset, CPU core on the same clock.
// Notes:   Each address, field position and reset value is named here once.
// Function
// RULE1 - Provide 256 bytes of internal RAM at addresses 0x00 through 0xFF.
// RULE2 - Lower 128 bytes are reachable by direct and by indirect addressing.
// RULE3 - Bytes 0x00 to 0x1F form four banks of eight working registers.
// RULE4 - Bytes 0x20 to 0x2F are reachable as bytes or as 128 bits.
// RULE5 - Upper 128 bytes are reachable only indirectly, separate from special registers.
// RULE6 - Above 0x7F, direct reaches special register space, indirect reaches upper RAM.
// RULE7 - One bank is active, chosen by status word bits 3 and 4.
// RULE8 - Indirect accesses take their address from working registers zero or one.
// RULE9 - Bit address maps linearly: 0x00 is 0x20 bit 0, 0x7F is 0x2F bit 7.
// RULE10 - Bit or byte access is chosen by operand type only, never by address.
// RULE11 - Pointer at 0x81 holds last used slot; push writes pointer plus one, then increments.
// RULE12 - Any reset loads the pointer with 0x07, so first push lands at 0x08.
// RULE13 - The stack may sit anywhere in the 256 bytes and span all of it.
// RULE14 - Direct accesses to 0x80 through 0xFF go to special function register space.
// RULE15 - Software treats undefined special register addresses as reserved and unreliable.
// RULE16 - Pop reads the byte at the pointer, then decrements the pointer.
package data_mem_pkg;

    localparam int         RAM_BYTES       = 256;
    localparam logic [7:0] STACK_PTR_ADDR  = 8'h81;
    localparam logic [7:0] STACK_PTR_RESET = 8'h07;
    localparam logic [3:0] BIT_AREA_HIGH   = 4'h2;
    localparam int         BANK_SEL_LOW_POS  = 3;
    localparam int         BANK_SEL_HIGH_POS = 4;
    localparam logic [7:0] FULL_BYTE_MASK  = 8'hFF;

    // Operation codes; the usual read, write, push, pop walk changes one bit per step.
    typedef enum logic [1:0] {
        OP_READ  = 2'b00,
        OP_WRITE = 2'b01,
        OP_PUSH  = 2'b11,
        OP_POP   = 2'b10
    } op_t;

    // Operand type of the instruction, which decides bit versus byte for every operation except push and pop.
    typedef enum logic [1:0] {
        MODE_DIRECT   = 2'b00,
        MODE_INDIRECT = 2'b01,
        MODE_BIT      = 2'b11
    } mode_t;

endpackage

// *** verilog/ram_store.sv ***
// Purpose: 256 by 8 flip-flop storage with one masked write port and two read ports.
// Assumes: Read ports are combinational; writes land on the clock edge.
// Notes:   Contents are not reset, as software owns every byte.
`timescale 1ns/1ps
module ram_store
    import data_mem_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic [7:0] wr_mask,
    input  wire logic [7:0] rd_addr_a,
    output logic      [7:0] rd_data_a,
    input  wire logic [7:0] rd_addr_b,
    output logic      [7:0] rd_data_b
);

    logic [7:0] mem_q [RAM_BYTES];
    logic [7:0] mem_d [RAM_BYTES];

    // Masked merge lets a single bit change without disturbing its neighbours.
    always_comb begin
        mem_d = mem_q;
        if (wr_en) begin
            mem_d[wr_addr] = (mem_q[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
        end
    end

    // Storage has no reset, so the whole array costs no reset wiring.
    always_ff @(posedge clk) begin
        mem_q <= mem_d;
    end

    // Both read ports see the stored value of this cycle.
    assign rd_data_a = mem_q[rd_addr_a];
    assign rd_data_b = mem_q[rd_addr_b];

endmodule // ram_store
